//--- hw/pmc_pkg.sv
package pmc_pkg;

   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [7:0] PCTL_OFFSET = 8'h87;
   localparam int PCTL_IDLE_BIT = 0;
   localparam int PCTL_PDOWN_BIT = 1;
   localparam logic [7:0] PCTL_RESET = 8'h00;
   // bit 5 is reserved and reads zero
   localparam logic [7:0] PCTL_RW_MASK = 8'hDF;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int OSC_SETTLE_NS = 10000;
   // least time, so round up to whole cycles
   localparam int OSC_SETTLE_CYCLES = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int EXT_INT_COUNT = 2;
   localparam int KBI_COUNT = 8;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {st_run, st_idle, st_pdown, st_osc_wait} pmc_state_t;

   typedef enum logic [2:0] {
      src_none, src_irq, src_ext, src_kbi, src_bod, src_wdt, src_reset
   } pmc_wake_src_t;

   // reset requests from the reset controller, one cycle pulses
   typedef struct packed {
      logic ext_pin;
      logic power_on;
      logic brownout;
      logic watchdog;
      logic software;
   } pmc_rst_req_t;

   // clock gates and freeze controls toward the core
   typedef struct packed {
      logic cpu_clk_en;
      logic periph_clk_en;
      logic flash_clk_en;
      logic pc_hold;
      logic fetch_block;
      logic port_hold;
   } pmc_clk_ctl_t;

endpackage

//--- hw/pmc_sync.sv
`timescale 1ns/1ps
// three flop synchroniser; the output moves only when stages two and three agree
module pmc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] s1, s2, s3;

   initial begin
      if (WIDTH < 1) $error("pmc_sync: WIDTH must be at least 1");
   end

   // s1 feeds s2 only; filtering looks at s2 and s3
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= (s2 & s3) | (q & (s2 | s3));
      end
   end
endmodule

//--- hw/pmc_settle.sv
`timescale 1ns/1ps
// counts the oscillator settling time after a restart
module pmc_settle #(
   parameter int CYCLES = pmc_pkg::OSC_SETTLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic abort,
   output logic done
);
   import pmc_pkg::*;
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
   logic [CW-1:0] count;
   logic running;

   initial begin
      if (CYCLES < 1) $error("pmc_settle: CYCLES must be at least 1");
   end

   assign done = running && (count == LAST);

   // start restarts the count; done is high in the last counted cycle
   always_ff @(posedge clk) begin
      if (!rst_n || abort) begin
         running <= 1'b0;
         count <= '0;
      end else if (start) begin
         running <= 1'b1;
         count <= '0;
      end else if (done) begin
         running <= 1'b0;
      end else if (running) begin
         count <= count + CW'(1);
      end
   end
endmodule

//--- hw/pmc_top.sv
`timescale 1ns/1ps
module pmc_top #(
   parameter int EXT_N = pmc_pkg::EXT_INT_COUNT,
   parameter int KBI_N = pmc_pkg::KBI_COUNT,
   parameter int SETTLE_CYCLES = pmc_pkg::OSC_SETTLE_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // interrupt controller, same clock
   input wire logic irq_pending,
   input wire logic global_int_en,
   input wire logic [EXT_N-1:0] ext_int_en,
   input wire logic [KBI_N-1:0] kbi_en,
   input wire logic brownout_det_en,
   // asynchronous wake sources
   input wire logic [EXT_N-1:0] ext_int_pin,
   input wire logic [KBI_N-1:0] kbi_pin,
   input wire logic brownout_irq,
   input wire logic watchdog_irq,
   // reset controller requests
   input wire pmc_pkg::pmc_rst_req_t rst_req,
   // core controls
   output pmc_pkg::pmc_clk_ctl_t clk_ctl,
   output logic osc_enable,
   output logic watchdog_clear,
   output logic wake_vector,
   output pmc_pkg::pmc_wake_src_t wake_src,
   output logic cpu_restart
);
   import pmc_pkg::*;

   // ----------------------------------------
   // parameter checks
   // ----------------------------------------
   initial begin
      if (EXT_N < 1 || EXT_N > 8) $error("pmc_top: EXT_N out of range");
      if (KBI_N < 1 || KBI_N > 8) $error("pmc_top: KBI_N out of range");
      if (SETTLE_CYCLES < 1) $error("pmc_top: SETTLE_CYCLES below one");
   end

   // ----------------------------------------
   // synchronised wake sources
   // ----------------------------------------
   localparam int SW = EXT_N + KBI_N + 2;
   logic [SW-1:0] wake_sync;
   logic [EXT_N-1:0] ext_s;
   logic [KBI_N-1:0] kbi_s;
   logic bod_s, wdt_s;

   pmc_sync #(.WIDTH(SW)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({ext_int_pin, kbi_pin, brownout_irq, watchdog_irq}),
      .q(wake_sync)
   );

   assign {ext_s, kbi_s, bod_s, wdt_s} = wake_sync;

   // ----------------------------------------
   // state and held context
   // ----------------------------------------
   pmc_state_t state, next_state;
   logic [7:0] pctl;
   logic [KBI_N-1:0] kbi_ref;
   logic bod_armed;
   logic settle_done;

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   wire pctl_wr = reg_wr && (reg_addr == PCTL_OFFSET);
   wire pctl_rd = reg_rd && (reg_addr == PCTL_OFFSET);
   wire wr_pdown = pctl_wr && reg_wdata[PCTL_PDOWN_BIT];
   // power-down takes precedence when both bits are written
   wire wr_idle = pctl_wr && reg_wdata[PCTL_IDLE_BIT] && !reg_wdata[PCTL_PDOWN_BIT];
   wire entering = (state == st_run) && (wr_pdown || wr_idle);

   // ----------------------------------------
   // wake and reset qualification
   // ----------------------------------------
   wire [EXT_N-1:0] ext_qual = ext_s & ext_int_en & {EXT_N{global_int_en}};
   // a change away from the level seen at entry is the only edge that wakes
   wire [KBI_N-1:0] kbi_qual = (kbi_s ^ kbi_ref) & kbi_en;
   wire pd_wake = (|ext_qual) || (|kbi_qual) || bod_s || wdt_s;
   wire rst_any = rst_req.ext_pin || rst_req.power_on || rst_req.watchdog || rst_req.brownout;
   // brownout reset only reaches a core in st_pdown when detection was armed
   wire rst_pd = rst_req.ext_pin || rst_req.power_on || rst_req.watchdog
      || (rst_req.brownout && bod_armed);
   wire rst_cold = rst_req.ext_pin || rst_req.power_on;

   // raw path from pins: no clock edge needed to start the oscillator again
   wire raw_wake = (|(ext_int_pin & ext_int_en & {EXT_N{global_int_en}}))
      || (|((kbi_pin ^ kbi_ref) & kbi_en)) || brownout_irq || watchdog_irq;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         st_run: begin
            if (wr_pdown) begin
               next_state = st_pdown;
            end else if (wr_idle) begin
               next_state = st_idle;
            end
         end
         st_idle: begin
            // peripherals still run, so any enabled interrupt or any reset but the software one resumes
            if (irq_pending || rst_any) begin
               next_state = st_run;
            end
         end
         st_pdown: begin
            if (rst_pd) begin
               next_state = st_run;
            end else if (pd_wake) begin
               next_state = st_osc_wait;
            end
         end
         st_osc_wait: begin
            // never back to idle, even if idle was also requested
            if (rst_any || settle_done) begin
               next_state = st_run;
            end
         end
         default: next_state = st_run;
      endcase
   end

   // ----------------------------------------
   // settle timer
   // ----------------------------------------
   pmc_settle #(.CYCLES(SETTLE_CYCLES)) u_settle (
      .clk(clk),
      .rst_n(rst_n),
      .start(state == st_pdown && next_state == st_osc_wait),
      .abort(state != st_osc_wait && state != st_pdown),
      .done(settle_done)
   );

   // ----------------------------------------
   // state, entry context
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= st_run;
         kbi_ref <= '0;
         bod_armed <= 1'b0;
      end else begin
         state <= next_state;
         if (wr_pdown && state == st_run) begin
            kbi_ref <= kbi_s;
            bod_armed <= brownout_det_en;
         end
      end
   end

   // ----------------------------------------
   // power control register
   // ----------------------------------------
   // hardware clears a request bit on the way back to run; a write, the set,
   // takes precedence over that clear in the same cycle, so it can never be lost to it
   wire leaving = (state != st_run) && (next_state == st_run);
   logic [7:0] next_pctl;
   always_comb begin
      next_pctl = pctl;
      if (leaving) begin
         next_pctl[PCTL_PDOWN_BIT] = 1'b0;
         next_pctl[PCTL_IDLE_BIT] = 1'b0;
      end
      if (pctl_wr) begin
         next_pctl = (reg_wdata & PCTL_RW_MASK);
         if (reg_wdata[PCTL_PDOWN_BIT]) begin
            next_pctl[PCTL_IDLE_BIT] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pctl <= PCTL_RESET;
      end else begin
         pctl <= next_pctl;
      end
   end

   // read data stand only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= pctl_rd ? (pctl & PCTL_RW_MASK) : 8'h00;
      end
   end

   // ----------------------------------------
   // clock gates and freeze
   // ----------------------------------------
   // gated in the same cycle as the write, so the writer is the last instruction
   wire deep = (state == st_pdown) || (state == st_osc_wait);
   assign clk_ctl.cpu_clk_en = (state == st_run) && !entering;
   assign clk_ctl.fetch_block = !clk_ctl.cpu_clk_en;
   assign clk_ctl.pc_hold = !clk_ctl.cpu_clk_en;
   assign clk_ctl.periph_clk_en = !deep && !(state == st_run && wr_pdown);
   assign clk_ctl.flash_clk_en = clk_ctl.periph_clk_en;
   assign clk_ctl.port_hold = (state != st_run);
   // combinational from the pins: the oscillator restarts with clk stopped
   assign osc_enable = (state != st_pdown) || raw_wake;

   // ----------------------------------------
   // wake reporting and watchdog clear
   // ----------------------------------------
   pmc_wake_src_t next_src;
   always_comb begin
      next_src = src_none;
      if (rst_any) begin
         next_src = src_reset;
      end else if (state == st_idle) begin
         next_src = src_irq;
      end else if (|ext_qual) begin
         next_src = src_ext;
      end else if (|kbi_qual) begin
         next_src = src_kbi;
      end else if (bod_s) begin
         next_src = src_bod;
      end else if (wdt_s) begin
         next_src = src_wdt;
      end
   end

   wire wake_edge = (state == st_idle || state == st_pdown) && (next_state != state);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         watchdog_clear <= 1'b0;
         wake_vector <= 1'b0;
         wake_src <= src_none;
         cpu_restart <= 1'b0;
      end else begin
         watchdog_clear <= entering || wake_edge;
         // the core vectors to the waking routine, then returns after the sleep write
         wake_vector <= leaving && !rst_any;
         cpu_restart <= leaving && rst_cold;
         if (wake_edge) begin
            wake_src <= next_src;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   pdown_entry_a: assert property (
      (state == st_run && wr_pdown) |-> !clk_ctl.cpu_clk_en ##1
      (state == st_pdown && !clk_ctl.periph_clk_en && pctl[PCTL_PDOWN_BIT]))
      else $error("power-down not entered on request");
   both_bits_a: assert property (
      (state == st_run && pctl_wr && reg_wdata[1:0] == 2'b11) |=>
      (state == st_pdown && !pctl[PCTL_IDLE_BIT]))
      else $error("both bits did not give power-down only");
   idle_gate_a: assert property (
      (state == st_idle) |-> (!clk_ctl.cpu_clk_en && clk_ctl.periph_clk_en && clk_ctl.pc_hold))
      else $error("idle gating wrong");
   idle_wake_a: assert property (
      (state == st_idle && irq_pending && !rst_any) |=>
      (state == st_run && !pctl[PCTL_IDLE_BIT] && wake_vector))
      else $error("enabled interrupt did not end idle");
   sw_reset_a: assert property (
      (state == st_idle && !irq_pending && !rst_any && rst_req.software) |=> state == st_idle)
      else $error("software reset ended idle");
   wdt_clear_a: assert property (
      (state == st_run && $past(state) != st_run && $past(state) != st_osc_wait)
      |-> watchdog_clear)
      else $error("watchdog not cleared on wake");
   settle_hold_a: assert property (
      (state == st_pdown && !rst_pd && pd_wake && !$past(pd_wake))
      ##1 (!rst_any) [*2] |-> !clk_ctl.cpu_clk_en)
      else $error("cpu released before oscillator settled");
   bod_arm_a: assert property (
      (state == st_pdown && !bod_armed && rst_req.brownout && !rst_pd && !pd_wake)
      |=> state == st_pdown)
      else $error("unarmed brownout ended power-down");
   cold_restart_a: assert property (
      (state == st_pdown && rst_cold) |=> cpu_restart)
      else $error("cold reset did not restart cpu");
   osc_async_a: assert property (
      (state == st_pdown && raw_wake) |-> osc_enable)
      else $error("oscillator not restarted by raw wake");
endmodule

//--- tb/pmc_partner.sv
`timescale 1ns/1ps
// --------------------------------------------
// interrupt controller and brownout detector
// --------------------------------------------
module pmc_partner (
   // requests from the bench
   input wire logic irq_src,
   input wire logic irq_src_en,
   input wire logic global_int_en,
   input wire logic bod_wanted,
   // toward the sequencer
   output logic irq_pending,
   output logic brownout_det_en
);
   // a source counts only with its own and the global enable set
   assign irq_pending = irq_src & irq_src_en & global_int_en;
   // detector stays off unless a brownout wake is wanted, it costs current
   assign brownout_det_en = bod_wanted;
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
   import pmc_pkg::*;
   localparam int SETTLE = 4;
   logic clk, rst_n, reg_wr, reg_rd, irq_src, irq_src_en, irq_pending, global_int_en;
   logic bod_wanted, brownout_det_en, brownout_irq, watchdog_irq;
   logic osc_enable, watchdog_clear, wake_vector, cpu_restart;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, kbi_en, kbi_pin, v, d, lvl;
   logic [1:0] ext_int_en, ext_int_pin;
   logic [31:0] lfsr;
   pmc_rst_req_t rst_req;
   pmc_clk_ctl_t clk_ctl;
   pmc_wake_src_t wake_src;
   int n_errors, samples_checked, n;

   pmc_top #(.SETTLE_CYCLES(SETTLE)) pmc_top_inst (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq_pending(irq_pending), .global_int_en(global_int_en),
      .ext_int_en(ext_int_en), .kbi_en(kbi_en), .brownout_det_en(brownout_det_en),
      .ext_int_pin(ext_int_pin), .kbi_pin(kbi_pin), .brownout_irq(brownout_irq),
      .watchdog_irq(watchdog_irq), .rst_req(rst_req), .clk_ctl(clk_ctl),
      .osc_enable(osc_enable), .watchdog_clear(watchdog_clear),
      .wake_vector(wake_vector), .wake_src(wake_src), .cpu_restart(cpu_restart));
   pmc_partner pmc_partner_inst (.irq_src(irq_src), .irq_src_en(irq_src_en),
      .global_int_en(global_int_en), .bod_wanted(bod_wanted),
      .irq_pending(irq_pending), .brownout_det_en(brownout_det_en));

   // --------------------------------------------
   // helpers
   // --------------------------------------------
   function automatic logic [7:0] rand8();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction
   function automatic pmc_wake_src_t exp_src(int k);
      case (k)
         0: return src_ext;
         1: return src_kbi;
         2: return src_bod;
         default: return src_wdt;
      endcase
   endfunction
   task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask
   task automatic cyc(int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   // bus cycles: strobe held through exactly one sampling edge
   task automatic wr(logic [7:0] a, logic [7:0] w);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= w;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] r);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      r = reg_rdata;
   endtask
   task automatic pulse_rst(logic [4:0] r);
      @(posedge clk);
      rst_req <= pmc_rst_req_t'(r);
      @(posedge clk);
      rst_req <= pmc_rst_req_t'(5'h00);
      #1;
   endtask
   // bounded wait for the cpu clock to come back; c counts cycles spent
   task automatic wait_run(output int c);
      c = 0;
      while (clk_ctl.cpu_clk_en !== 1'b1 && c < 40) begin
         cyc(1);
         c++;
      end
      if (c >= 40) begin
         $display("unexpected wake wait: no return to run");
         n_errors++;
         summarize();
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // --------------------------------------------
   // main sequence
   // --------------------------------------------
   initial begin
      {rst_n, reg_wr, reg_rd, irq_src, brownout_irq, watchdog_irq, bod_wanted} = '0;
      {reg_addr, reg_wdata, kbi_pin, ext_int_pin} = '0;
      {irq_src_en, global_int_en} = 2'b11;
      ext_int_en = 2'b01;
      kbi_en = 8'hFF;
      rst_req = pmc_rst_req_t'(5'h00);
      lfsr = 32'hC285;
      n_errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      // register: reset value, random storage bits, unmapped places
      rd(PCTL_OFFSET, d);
      chk("power_control reset", PCTL_RESET, d);
      for (int i = 0; i < 6; i++) begin
         v = rand8() & 8'hFC;
         wr(PCTL_OFFSET, v);
         wr(8'h86, 8'hFF);
         rd(PCTL_OFFSET, d);
         chk("power_control", v & PCTL_RW_MASK, d);
         rd(8'h88, d);
         chk("unmapped read", 8'h00, d);
      end
      wr(PCTL_OFFSET, 8'h00);
      // idle, software reset refused, interrupt wake
      wr(PCTL_OFFSET, 8'h01);
      chk("idle cpu clk", 8'h00, 8'(clk_ctl.cpu_clk_en));
      chk("idle periph clk", 8'h01, 8'(clk_ctl.periph_clk_en));
      chk("idle pc hold", 8'h01, 8'(clk_ctl.pc_hold));
      chk("idle fetch block", 8'h01, 8'(clk_ctl.fetch_block));
      chk("idle wd clear", 8'h01, 8'(watchdog_clear));
      pulse_rst(5'b00001);
      cyc(2);
      chk("idle after sw reset", 8'h00, 8'(clk_ctl.cpu_clk_en));
      irq_src <= 1'b1;
      wait_run(n);
      chk("idle exit wd clear", 8'h01, 8'(watchdog_clear));
      chk("idle wake src", 8'(src_irq), 8'(wake_src));
      chk("idle wake vector", 8'h01, 8'(wake_vector));
      irq_src <= 1'b0;
      cyc(1);
      rd(PCTL_OFFSET, d);
      chk("idle bit cleared", 8'h00, d);
      // idle ended by pin reset: no vector
      wr(PCTL_OFFSET, 8'h01);
      pulse_rst(5'b10000);
      chk("idle reset exit", 8'h01, 8'(clk_ctl.cpu_clk_en));
      chk("idle reset src", 8'(src_reset), 8'(wake_src));
      cyc(1);
      chk("no vector on reset", 8'h00, 8'(wake_vector));
      // power-down woken by each source in turn
      for (int k = 0; k < 4; k++) begin
         lvl = rand8();
         kbi_pin <= lvl;
         bod_wanted <= (k == 2);
         global_int_en <= (k != 0);
         cyc(4);
         wr(PCTL_OFFSET, (k == 0) ? 8'h03 : 8'h02);
         chk("pd cpu clk", 8'h00, 8'(clk_ctl.cpu_clk_en));
         chk("pd periph clk", 8'h00, 8'(clk_ctl.periph_clk_en));
         chk("pd flash clk", 8'h00, 8'(clk_ctl.flash_clk_en));
         chk("pd osc", 8'h00, 8'(osc_enable));
         chk("pd port hold", 8'h01, 8'(clk_ctl.port_hold));
         if (k == 0) begin
            ext_int_pin <= 2'b01;
            cyc(8);
            chk("ext pin no global", 8'h00, 8'(osc_enable));
            global_int_en <= 1'b1;
            cyc(0);
            chk("ext osc restart", 8'h01, 8'(osc_enable));
         end
         else if (k == 1) kbi_pin <= lvl ^ (8'h01 << (rand8() & 8'h07));
         else if (k == 2) brownout_irq <= 1'b1;
         else watchdog_irq <= 1'b1;
         wait_run(n);
         chk("osc settle wait", 8'h01, 8'(n >= SETTLE));
         chk("pd wake src", 8'(exp_src(k)), 8'(wake_src));
         chk("pd wake vector", 8'h01, 8'(wake_vector));
         cyc(1);
         {ext_int_pin, brownout_irq, watchdog_irq} <= '0;
         rd(PCTL_OFFSET, d);
         chk("pd bits cleared", 8'h00, d);
         cyc(3);
         chk("no idle after pd", 8'h01, 8'(clk_ctl.cpu_clk_en));
      end
      // unarmed brownout reset ignored, power-on reset restarts the cpu
      bod_wanted <= 1'b0;
      wr(PCTL_OFFSET, 8'h02);
      pulse_rst(5'b00100);
      cyc(3);
      chk("unarmed bod reset", 8'h00, 8'(clk_ctl.cpu_clk_en));
      pulse_rst(5'b01000);
      chk("por ends pd", 8'h01, 8'(clk_ctl.cpu_clk_en));
      chk("cpu restart", 8'h01, 8'(cpu_restart));
      chk("no vector on por", 8'h00, 8'(wake_vector));
      cyc(1);
      summarize();
   end
endmodule
